// ---- rtl/bioe_core.sv ----
// instruction execute core for jump, increments and inclusive or
`timescale 1ns/1ps
module bioe_core (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [13:0] instr_word,
   input  wire logic [7:0]  page_latch,
   input  wire logic [7:0]  file_rdata,
   output logic      [12:0] program_counter,
   output logic      [7:0]  acc_value,
   output logic             zero_flag,
   output logic      [6:0]  file_addr,
   output logic      [7:0]  file_wdata,
   output logic             file_we,
   output logic             nop_cycle
);
   typedef struct packed {
      bioe_pkg::bioe_state_e st;
      logic [12:0]           pc;
      logic [7:0]            acc;
      logic                  zero;
      logic [6:0]            waddr;
      logic [7:0]            wdata;
      logic                  we;
      logic                  no_operation;
   } bioe_core_s;

   bioe_core_s state_reg;
   bioe_core_s state_next;

   logic       accept;
   logic       is_jump;
   logic       is_inc;
   logic       is_inc_skip;
   logic       is_or_reg;
   logic       is_or_lit;
   logic       dest_file;
   logic       use_or;
   logic [7:0] alu_result;
   logic       alu_zero;

   // decode; the file read data must match instr_word[6:0] in the same cycle
   assign accept      = instr_valid && (state_reg.st == bioe_pkg::BIOE_ST_EXEC);
   assign is_jump     = instr_word[bioe_pkg::OP_HI:bioe_pkg::OP3_LO] == bioe_pkg::OP_JUMP;
   assign is_inc      = instr_word[bioe_pkg::OP_HI:bioe_pkg::OP6_LO] == bioe_pkg::OP_INC_REG;
   assign is_inc_skip = instr_word[bioe_pkg::OP_HI:bioe_pkg::OP6_LO] == bioe_pkg::OP_INC_SKIP;
   assign is_or_reg   = instr_word[bioe_pkg::OP_HI:bioe_pkg::OP6_LO] == bioe_pkg::OP_OR_ACC_REG;
   assign is_or_lit   = instr_word[bioe_pkg::OP_HI:bioe_pkg::OP6_LO] == bioe_pkg::OP_OR_LIT;
   assign dest_file   = instr_word[bioe_pkg::DEST_BIT];
   assign use_or      = is_or_reg || is_or_lit;

   bioe_alu u_alu (
      .use_or      (use_or),
      .use_lit     (is_or_lit),
      .acc_val     (state_reg.acc),
      .file_val    (file_rdata),
      .lit_val     (instr_word[7:0]),
      .result      (alu_result),
      .result_zero (alu_zero)
   );

   // next state; unknown opcodes just advance the counter like a no-operation
   always_comb begin
      state_next     = state_reg;
      state_next.we  = 1'b0;
      state_next.no_operation = 1'b0;
      unique case (state_reg.st)
         bioe_pkg::BIOE_ST_EXEC: begin
            if (accept) begin
               state_next.pc = 13'(state_reg.pc + bioe_pkg::PC_STEP);
               if (is_jump) begin
                  // flags untouched, one flush cycle follows
                  state_next.pc[10:0]  = instr_word[10:0]; // RL1
                  state_next.pc[12:11] = page_latch[bioe_pkg::PAGE_HI_BIT:
                                                    bioe_pkg::PAGE_LO_BIT]; // RL2
                  state_next.st        = bioe_pkg::BIOE_ST_FLUSH; // RL3
               end else if (is_inc || is_inc_skip || is_or_reg) begin
                  if (dest_file) begin
                     state_next.we    = 1'b1; // RL4 RL5 RL7
                     state_next.waddr = instr_word[6:0];
                     state_next.wdata = alu_result;
                  end else begin
                     state_next.acc = alu_result; // RL4 RL5 RL7
                  end
                  if (!is_inc_skip) begin // RL6
                     state_next.zero = alu_zero; // RL7 RL9
                  end
                  // counter steps two from the current word, past the skipped word
                  if (is_inc_skip && alu_zero) begin
                     state_next.pc = 13'(state_reg.pc + bioe_pkg::PC_SKIP); // RL5
                     state_next.st = bioe_pkg::BIOE_ST_FLUSH; // RL5
                  end
               end else if (is_or_lit) begin
                  state_next.acc  = alu_result; // RL8
                  state_next.zero = alu_zero; // RL8 RL9
               end
            end
         end
         bioe_pkg::BIOE_ST_FLUSH: begin
            // the word fetched during this cycle is discarded
            state_next.no_operation = 1'b1; // RL3 RL5
            state_next.st  = bioe_pkg::BIOE_ST_EXEC;
         end
      endcase
   end

   // one register stage for all state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg       <= '0;
         state_reg.st    <= bioe_pkg::BIOE_ST_EXEC;
         state_reg.pc    <= bioe_pkg::PC_RST;
         state_reg.acc   <= bioe_pkg::ACC_RST;
         state_reg.zero  <= bioe_pkg::ZERO_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign program_counter = state_reg.pc;
   assign acc_value       = state_reg.acc;
   assign zero_flag       = state_reg.zero;
   assign file_addr       = state_reg.waddr;
   assign file_wdata      = state_reg.wdata;
   assign file_we         = state_reg.we;
   assign nop_cycle       = state_reg.no_operation;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_flush_once;
      !nop_cycle ##1 nop_cycle ##1 !nop_cycle;
   endsequence

   sequence s_flag_held;
      $stable(zero_flag) ##1 $stable(zero_flag);
   endsequence

   property p_jump_low;
      accept && is_jump |=> program_counter[10:0] == $past(instr_word[10:0]);
   endproperty
   a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong"); // RL1

   property p_jump_page;
      accept && is_jump |=> program_counter[12:11] == $past(page_latch[4:3]);
   endproperty
   a_jump_page: assert property (p_jump_page) else $error("jump page bits wrong"); // RL2

   property p_jump_two_cycles;
      accept && is_jump |=> s_flush_once and s_flag_held;
   endproperty
   a_jump_two_cycles: assert property (p_jump_two_cycles) else $error("jump timing"); // RL3

   property p_or_reg;
      accept && is_or_reg |=> (file_we == $past(dest_file))
         && (($past(dest_file) ? file_wdata : acc_value)
             == ($past(state_reg.acc) | $past(file_rdata)));
   endproperty
   a_or_reg: assert property (p_or_reg) else $error("or with register wrong"); // RL4

   property p_skip_zero;
      accept && is_inc_skip && (file_rdata == 8'hff) |=> s_flush_once;
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("skip missing"); // RL5

   property p_skip_nonzero;
      accept && is_inc_skip && (file_rdata != 8'hff)
         |=> !nop_cycle && $stable(zero_flag)
             && program_counter == 13'($past(program_counter) + 13'h0001);
   endproperty
   a_skip_nonzero: assert property (p_skip_nonzero) else $error("bad skip"); // RL6

   property p_inc_acc;
      accept && is_inc && !dest_file
         |=> acc_value == 8'($past(file_rdata) + 8'h01) && !file_we;
   endproperty
   a_inc_acc: assert property (p_inc_acc) else $error("increment wrong"); // RL7

   property p_or_lit;
      accept && is_or_lit |=> acc_value == ($past(state_reg.acc) | $past(instr_word[7:0]));
   endproperty
   a_or_lit: assert property (p_or_lit) else $error("or literal wrong"); // RL8

   property p_zero_flag;
      accept && (is_or_lit || ((is_inc || is_or_reg) && !dest_file))
         |=> zero_flag == (acc_value == 8'h00);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RL9

   // steps that the checks above leave open
   sequence s_skip_step;
      program_counter == 13'($past(program_counter) + 13'h0002);
   endsequence

   property p_skip_pc;
      accept && is_inc_skip && (file_rdata == 8'hff) |=> s_skip_step ##0 $stable(zero_flag);
   endproperty
   a_skip_pc: assert property (p_skip_pc) else $error("skip counter or flag wrong"); // RL5 RL6

   property p_flush_ignores;
      state_reg.st == bioe_pkg::BIOE_ST_FLUSH
         |=> !file_we && $stable(acc_value) && $stable(zero_flag) && $stable(program_counter);
   endproperty
   a_flush_ignores: assert property (p_flush_ignores) else $error("flush word ran"); // RL3 RL5

   property p_zero_to_file;
      accept && (is_inc || is_or_reg) && dest_file
         |=> file_we && (zero_flag == (file_wdata == 8'h00));
   endproperty
   a_zero_to_file: assert property (p_zero_to_file) else $error("file zero flag wrong"); // RL9

   property p_inc_file;
      accept && is_inc && dest_file
         |=> file_we && file_addr == $past(instr_word[6:0])
             && file_wdata == 8'($past(file_rdata) + 8'h01);
   endproperty
   a_inc_file: assert property (p_inc_file) else $error("increment to file wrong"); // RL7

   property p_nop_single;
      nop_cycle |=> !nop_cycle;
   endproperty
   a_nop_single: assert property (p_nop_single) else $error("no-operation too long"); // RL3 RL5
endmodule : bioe_core

// ---- common/bioe_pkg.sv ----
// package of constants, encodings and helpers for the branch, increment and or block
// Notes on behaviour
// [RL1] A jump loads its 11-bit immediate into program counter bits 10 down to 0.
// [RL2] A jump fills program counter bits 12 and 11 from bits 4 and 3 of the page latch.
// [RL3] A jump takes two instruction cycles and leaves every status flag unchanged.
// [RL4] Or-with-register ors acc with the file register, into acc if d is 0, else into the file.
// [RL5] Increment-and-skip adds one, steers by d, and on a zero result runs a no-operation next.
// [RL6] Increment-and-skip with a nonzero result runs the next word and never touches a flag.
// [RL7] Plain increment adds one to a register addressed by 7 bits, steers by d and updates zero.
// [RL8] Or-literal ors the accumulator with an 8-bit literal into acc and updates zero.
// [RL9] Where zero is affected it is set on a zero 8-bit result and cleared otherwise.
package bioe_pkg;
   localparam int unsigned PC_W    = 13;
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned ADDR_W  = 7;
   localparam int unsigned INSTR_W = 14;
   localparam int unsigned IMM_W   = 11;

   // field positions inside the instruction word and the page latch
   localparam int unsigned DEST_BIT    = 7;
   localparam int unsigned OP_HI       = 13;
   localparam int unsigned OP6_LO      = 8;
   localparam int unsigned OP3_LO      = 11;
   localparam int unsigned PAGE_HI_BIT = 4;
   localparam int unsigned PAGE_LO_BIT = 3;

   // opcode patterns, top bits of the instruction word
   localparam logic [2:0] OP_JUMP       = 3'h5;
   localparam logic [5:0] OP_INC_REG    = 6'h0a;
   localparam logic [5:0] OP_INC_SKIP   = 6'h0f;
   localparam logic [5:0] OP_OR_ACC_REG = 6'h04;
   localparam logic [5:0] OP_OR_LIT     = 6'h38;

   // reset values and step sizes
   localparam logic [12:0] PC_RST    = 13'h0000;
   localparam logic [7:0]  ACC_RST   = 8'h00;
   localparam logic        ZERO_RST  = 1'b0;
   localparam logic [7:0]  DATA_ZERO = 8'h00;
   localparam logic [7:0]  DATA_ONE  = 8'h01;
   localparam logic [12:0] PC_STEP   = 13'h0001;
   localparam logic [12:0] PC_SKIP   = 13'h0002;

   typedef enum logic {BIOE_ST_EXEC, BIOE_ST_FLUSH} bioe_state_e;

   // zero test used by the alu for result_zero; the core checks compare with 8'h00
   function automatic logic is_zero(input logic [7:0] value);
      is_zero = (value == DATA_ZERO);
   endfunction : is_zero
endpackage : bioe_pkg

// ---- rtl/bioe_alu.sv ----
// combinational datapath: increment or inclusive or, with zero detect
`timescale 1ns/1ps
module bioe_alu (
   input  wire logic       use_or,
   input  wire logic       use_lit,
   input  wire logic [7:0] acc_val,
   input  wire logic [7:0] file_val,
   input  wire logic [7:0] lit_val,
   output logic      [7:0] result,
   output logic            result_zero
);
   // the or operand comes from the literal or the file register
   always_comb begin
      if (use_or) begin
         result = acc_val | (use_lit ? lit_val : file_val); // RL4 RL8
      end else begin
         result = 8'(file_val + bioe_pkg::DATA_ONE); // RL5 RL7
      end
      result_zero = bioe_pkg::is_zero(result); // RL9
   end
endmodule : bioe_alu

// ---- tb/testbench.sv ----
// self-checking bench for the jump, increment and or execute core
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [13:0] w;
      logic [7:0]  rd;
      logic [7:0]  acc;
      logic        z;
      logic [12:0] pc;
      logic        we;
      logic [6:0]  fa;
      logic [7:0]  fd;
   } bioe_tb_row_s;

   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        instr_valid = 1'b0;
   logic [13:0] instr_word = 14'h0000;
   logic [7:0]  page_latch = 8'h00;
   logic [7:0]  file_rdata = 8'h00;
   logic [12:0] program_counter;
   logic [7:0]  acc_value;
   logic        zero_flag;
   logic [6:0]  file_addr;
   logic [7:0]  file_wdata;
   logic        file_we;
   logic        nop_cycle;
   int          fails = 0;
   int          tests_run = 0;

   // ordinary cases run in order, so each row starts from the state the row before left
   bioe_tb_row_s rows [9] = '{
      '{14'h3800, 8'h00, 8'h00, 1'b1, 13'h0001, 1'b0, 7'h00, 8'h00},
      '{14'h38a5, 8'h00, 8'ha5, 1'b0, 13'h0002, 1'b0, 7'h00, 8'h00},
      '{14'h0a7f, 8'hff, 8'h00, 1'b1, 13'h0003, 1'b0, 7'h00, 8'h00},
      '{14'h0a92, 8'h41, 8'h00, 1'b0, 13'h0004, 1'b1, 7'h12, 8'h42},
      '{14'h0405, 8'h3c, 8'h3c, 1'b0, 13'h0005, 1'b0, 7'h00, 8'h00},
      '{14'h0486, 8'h00, 8'h3c, 1'b0, 13'h0006, 1'b1, 7'h06, 8'h3c},
      '{14'h0a01, 8'hff, 8'h00, 1'b1, 13'h0007, 1'b0, 7'h00, 8'h00},
      '{14'h0f01, 8'h10, 8'h11, 1'b1, 13'h0008, 1'b0, 7'h00, 8'h00},
      '{14'h0fa2, 8'h7e, 8'h11, 1'b1, 13'h0009, 1'b1, 7'h22, 8'h7f}};

   bioe_core dut (
      .core_clk        (core_clk),
      .rst_n           (rst_n),
      .instr_valid     (instr_valid),
      .instr_word      (instr_word),
      .page_latch      (page_latch),
      .file_rdata      (file_rdata),
      .program_counter (program_counter),
      .acc_value       (acc_value),
      .zero_flag       (zero_flag),
      .file_addr       (file_addr),
      .file_wdata      (file_wdata),
      .file_we         (file_we),
      .nop_cycle       (nop_cycle)
   );

   // free-running core clock, 10 ns period
   always #5 core_clk = ~core_clk;

   task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t pc got %h want %h", $time, got, exp);
      end
   endtask : chk13

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t data got %h want %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t flag got %b want %b", $time, got, exp);
      end
   endtask : chk1

   // caller sits at a falling edge; returns at the next one with the result settled
   task automatic issue(input logic [13:0] w, input logic [7:0] rd);
      instr_valid = 1'b1;
      instr_word  = w;
      file_rdata  = rd;
      @(negedge core_clk);
   endtask : issue

   // jump, then a word in the flush slot that must be dropped
   task automatic jump(input logic [7:0] pg, input logic [13:0] w, input logic [12:0] pc);
      page_latch = pg;
      issue(w, 8'h00);
      chk13(program_counter, pc);
      chk8(acc_value, 8'h11);
      chk1(zero_flag, 1'b1);
      issue(14'h0a00, 8'hff);
      chk13(program_counter, pc);
      chk8(acc_value, 8'h11);
      chk1(nop_cycle, 1'b1);
   endtask : jump

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // watchdog: the whole sequence needs well under 100 cycles
   initial begin
      #20000;
      fails++;
      report_and_stop();
   end

   initial begin
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         issue(rows[i].w, rows[i].rd);
         chk8(acc_value, rows[i].acc);
         chk1(zero_flag, rows[i].z);
         chk13(program_counter, rows[i].pc);
         chk1(file_we, rows[i].we);
         chk1(nop_cycle, 1'b0);
         if (rows[i].we) chk8({1'b0, file_addr}, {1'b0, rows[i].fa});
         if (rows[i].we) chk8(file_wdata, rows[i].fd);
      end
      // second jump enters straight after the no-operation cycle of the first
      jump(8'he8, 14'h2da3, 13'h0da3);
      jump(8'h17, 14'h2fff, 13'h17ff);
      issue(14'h3801, 8'h00);
      chk1(zero_flag, 1'b0);
      chk1(nop_cycle, 1'b0);
      // skip on zero into the file register, then into the accumulator
      issue(14'h0fb3, 8'hff);
      chk13(program_counter, 13'h1802);
      chk1(file_we, 1'b1);
      chk8(file_wdata, 8'h00);
      chk1(zero_flag, 1'b0);
      issue(14'h0a00, 8'hff);
      chk8(acc_value, 8'h11);
      chk1(nop_cycle, 1'b1);
      issue(14'h0f44, 8'hff);
      chk8(acc_value, 8'h00);
      chk13(program_counter, 13'h1804);
      chk1(zero_flag, 1'b0);
      issue(14'h3855, 8'h00);
      chk8(acc_value, 8'h00);
      chk1(nop_cycle, 1'b1);
      instr_valid = 1'b0;
      @(negedge core_clk);
      chk1(nop_cycle, 1'b0);
      // reset again in mid-run
      rst_n = 1'b0;
      @(negedge core_clk);
      chk13(program_counter, 13'h0000);
      chk8(acc_value, 8'h00);
      chk1(zero_flag, 1'b0);
      chk1(file_we, 1'b0);
      rst_n = 1'b1;
      // the first word after release is taken at the first edge
      issue(14'h38f0, 8'h00);
      chk8(acc_value, 8'hf0);
      chk13(program_counter, 13'h0001);
      chk1(zero_flag, 1'b0);
      report_and_stop();
   end
endmodule : testbench
